// file: pkg/lcr_pkg.sv
// shared types and constants for the logic cell latch ram and carry column
// assumes one system clock domain; user logic and neighbour cells share it
package lcr_pkg;

  // ram geometry: one look-up table used as a 16x1 store
  localparam int LCR_ADDR_W = 4;
  localparam int LCR_DEPTH = 16;
  localparam logic [LCR_DEPTH-1:0] LCR_MEM_RST = 16'h0000;
  localparam logic [LCR_ADDR_W-1:0] LCR_ADDR_RST = 4'h0;

  // carry column defaults
  localparam int LCR_CELLS = 4;
  localparam int LCR_SLICE_W = 2;
  localparam bit LCR_HIGH_CAP = 1'b0;

  // write side of the latch ram, driven by user logic
  typedef struct packed {
    logic we;
    logic [LCR_ADDR_W-1:0] addr;
    logic din;
  } lcr_ram_req_type;

  // operands of one cell; the same pins feed the look-up tables and the carry
  typedef struct packed {
    logic [LCR_SLICE_W-1:0] op_a;
    logic [LCR_SLICE_W-1:0] op_b;
    logic second_lut_input_four;
  } lcr_slice_in_type;

  // column configuration, normally fixed by the cell programming
  typedef struct packed {
    logic subtract;
    logic dir_down;
    logic init_en;
  } lcr_carry_cfg_type;

endpackage : lcr_pkg

// file: rtl/lcr_carry.sv
// one 2-bit adder slice of the dedicated carry chain
// assumes operands and carry in settle within the same system clock cycle
`timescale 1ns/10ps
`default_nettype none
module lcr_carry
  import lcr_pkg::*;
#(
  parameter bit HIGH_CAP = LCR_HIGH_CAP
) (
  input wire lcr_slice_in_type slice_in,
  input wire lcr_carry_cfg_type cfg,
  input wire logic bypass,
  input wire logic carry_in,
  output logic [LCR_SLICE_W-1:0] sum,
  output logic carry_out
);

  logic [LCR_SLICE_W-1:0] b_eff;
  logic [1:0] low_add;
  logic [1:0] high_add;
  logic chain_carry;

  // subtraction inverts the second operand; carry then means no borrow
  assign b_eff = cfg.subtract ? ~slice_in.op_b : slice_in.op_b;

  // lower table adds bit 0, its carry stays hidden inside the cell
  assign low_add = {1'b0, slice_in.op_a[0]} + {1'b0, b_eff[0]} + {1'b0, carry_in};
  assign high_add = {1'b0, slice_in.op_a[1]} + {1'b0, b_eff[1]} + {1'b0, low_add[1]};

  // carries return into the tables which form the sum bits
  assign sum = {high_add[0], low_add[0]};

  // bypass passes carry straight through; the high-capacity path has one
  // mux stage fewer, which only matters for delay, not for the value
  assign chain_carry = bypass ? carry_in : high_add[1];

  // high-capacity cells may load carry from the fourth input of table two
  assign carry_out = (HIGH_CAP && cfg.init_en) ? slice_in.second_lut_input_four
                                               : chain_carry;

endmodule : lcr_carry
`default_nettype wire

// file: rtl/lcr_cell.sv
// column of logic cells: level-sensitive look-up-table ram plus carry chain
// assumes user logic and neighbour columns run on clk_sys; every input is
// taken as settled at the rising edge, so the latch is modelled per cycle
//
// Overview of operation
// - write enable high writes data, no clock
// - held write enable acts as transparent latch
// - address change under enable writes spurious data
// - each table has dedicated carry logic
// - carry out feeds neighbouring cell directly
// - two tables form cascadable 2-bit adder
// - standard variant carries up or down
// - column end carry turns into right column
// - high-capacity chain runs upward only
// - high-capacity carry leaves top, no input above
// - carry shares operand inputs with tables
// - tables combine carries with operands into sums
// - high-capacity fourth input initialises carry
// - high-capacity bypass path drops one mux
`timescale 1ns/10ps
`default_nettype none
module lcr_cell
  import lcr_pkg::*;
#(
  parameter int CELLS = LCR_CELLS,
  parameter bit HIGH_CAP = LCR_HIGH_CAP
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire lcr_ram_req_type ram_req,
  output logic ram_rd_data,
  output logic ram_addr_glitch,
  input wire lcr_slice_in_type [CELLS-1:0] slice_in,
  input wire lcr_carry_cfg_type carry_cfg,
  input wire logic [CELLS-1:0] cell_bypass,
  input wire logic carry_in_from_below,
  input wire logic carry_in_from_above,
  output logic [LCR_SLICE_W*CELLS-1:0] sum_out,
  output logic carry_out
);

  localparam int SUM_W = LCR_SLICE_W * CELLS;

  // refuse a column the chain cannot be built for
  if (CELLS < 1) begin : g_bad_cells
    $error("lcr_cell: CELLS must be at least one");
  end

  typedef struct packed {
    logic [LCR_DEPTH-1:0] mem;
    logic we_d;
    logic [LCR_ADDR_W-1:0] addr_d;
    logic rd_data;
    logic glitch;
    logic [SUM_W-1:0] sum;
    logic carry_right;
  } lcr_state_type;

  lcr_state_type st_reg;
  lcr_state_type st_next;

  logic eff_down;
  logic addr_move;
  logic rd_now;
  logic [CELLS-1:0] cell_cin;
  logic [CELLS-1:0] cell_carry_out;
  logic [SUM_W-1:0] cell_sum;

  // downward carry exists only in the standard variant
  assign eff_down = !HIGH_CAP && carry_cfg.dir_down;

  // address moving while enable is still high from the previous cycle
  assign addr_move = ram_req.we && st_reg.we_d && (ram_req.addr != st_reg.addr_d);

  assign rd_now = st_reg.mem[ram_req.addr];

  // carry into each cell comes from its neighbour in the chosen direction;
  // the input from above is simply not looked at in the high-capacity variant
  for (genvar i = 0; i < CELLS; i++) begin : g_chain
    if (CELLS == 1) begin : g_single
      assign cell_cin[i] = eff_down ? carry_in_from_above : carry_in_from_below;
    end else if (i == 0) begin : g_bottom
      assign cell_cin[i] = eff_down ? cell_carry_out[i+1] : carry_in_from_below;
    end else if (i == CELLS - 1) begin : g_top
      assign cell_cin[i] = eff_down ? carry_in_from_above : cell_carry_out[i-1];
    end else begin : g_mid
      assign cell_cin[i] = eff_down ? cell_carry_out[i+1] : cell_carry_out[i-1];
    end

    lcr_carry #(
      .HIGH_CAP(HIGH_CAP)
    ) u_slice (
      .slice_in(slice_in[i]),
      .cfg(carry_cfg),
      .bypass(cell_bypass[i]),
      .carry_in(cell_cin[i]),
      .sum(cell_sum[LCR_SLICE_W*i +: LCR_SLICE_W]),
      .carry_out(cell_carry_out[i])
    );
  end

  // next state: latch ram write, read sample and column results
  always_comb begin
    st_next = st_reg;
    st_next.we_d = ram_req.we;
    st_next.addr_d = ram_req.addr;
    st_next.glitch = addr_move;
    if (ram_req.we) begin
      // every cycle of the high pulse rewrites the addressed bit, so the
      // value present at the falling edge is the one that remains
      if (addr_move) begin
        // the real cell corrupts the new word; inverted data stands in for it
        st_next.mem[ram_req.addr] = ~ram_req.din;
      end else begin
        st_next.mem[ram_req.addr] = ram_req.din;
      end
    end
    // read ignores the enable level; registered here, so it trails by one edge
    st_next.rd_data = rd_now;
    st_next.sum = cell_sum;
    // the end of the column hands its carry to the column on the right
    st_next.carry_right = eff_down ? cell_carry_out[0] : cell_carry_out[CELLS-1];
  end

  // state register, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg.mem <= LCR_MEM_RST;
      st_reg.we_d <= 1'b0;
      st_reg.addr_d <= LCR_ADDR_RST;
      st_reg.rd_data <= 1'b0;
      st_reg.glitch <= 1'b0;
      st_reg.sum <= '0;
      st_reg.carry_right <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs come straight from the state register
  assign ram_rd_data = st_reg.rd_data;
  assign ram_addr_glitch = st_reg.glitch;
  assign sum_out = st_reg.sum;
  assign carry_out = st_reg.carry_right;

  // helper words for checking the whole column as one adder
  logic [SUM_W-1:0] word_a;
  logic [SUM_W-1:0] word_b;
  logic [SUM_W:0] word_total;
  logic plain_up;

  always_comb begin
    word_a = '0;
    word_b = '0;
    for (int k = 0; k < CELLS; k++) begin
      word_a[LCR_SLICE_W*k +: LCR_SLICE_W] = slice_in[k].op_a;
      word_b[LCR_SLICE_W*k +: LCR_SLICE_W] = slice_in[k].op_b;
    end
    if (carry_cfg.subtract) begin
      word_b = ~word_b;
    end
    word_total = {1'b0, word_a} + {1'b0, word_b} + {{SUM_W{1'b0}}, carry_in_from_below};
  end

  assign plain_up = !eff_down && !carry_cfg.init_en && (cell_bypass == '0);

  // bottom cell worked out on its own, so one slice can be checked alone;
  // the operand choice repeats the slice logic on purpose, from the pins
  logic [LCR_SLICE_W-1:0] b_cell0;
  logic [LCR_SLICE_W:0] cell0_total;

  assign b_cell0 = carry_cfg.subtract ? ~slice_in[0].op_b : slice_in[0].op_b;
  assign cell0_total = {1'b0, slice_in[0].op_a} + {1'b0, b_cell0}
                       + {{LCR_SLICE_W{1'b0}}, cell_cin[0]};

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  ram_write_a: assert property (
    ram_req.we && !addr_move |=> st_reg.mem[$past(ram_req.addr)] == $past(ram_req.din))
    else $error("ram bit not written while enable high");

  latch_follow_a: assert property (
    ram_req.we ##1 (ram_req.we && !addr_move && $changed(ram_req.din))
    |=> st_reg.mem[$past(ram_req.addr)] == $past(ram_req.din))
    else $error("data change under enable not followed");

  spurious_write_a: assert property (
    addr_move |=> st_reg.glitch && (st_reg.mem[$past(ram_req.addr)] != $past(ram_req.din)))
    else $error("address move under enable not flagged");

  ram_hold_a: assert property (
    !ram_req.we |=> $stable(st_reg.mem))
    else $error("ram changed with enable low");

  read_path_a: assert property (
    ##1 1'b1 |-> ram_rd_data == $past(rd_now))
    else $error("read output does not show addressed bit");

  column_sum_a: assert property (
    plain_up |=> {carry_out, sum_out} == $past(word_total))
    else $error("column sum or carry wrong");

  carry_turn_a: assert property (
    1'b1 |=> carry_out == ($past(eff_down) ? $past(cell_carry_out[0]) : $past(cell_carry_out[CELLS-1])))
    else $error("column end carry not passed right");

  upward_only_a: assert property (
    HIGH_CAP |-> !eff_down && cell_cin[0] == carry_in_from_below)
    else $error("high-capacity chain not upward");

  above_ignored_a: assert property (
    HIGH_CAP && $changed(carry_in_from_above) && $stable(slice_in) && $stable(carry_cfg)
    && $stable(cell_bypass) && $stable(carry_in_from_below) |=> $stable(carry_out))
    else $error("carry from above reached a high-capacity column");

  init_path_a: assert property (
    HIGH_CAP && carry_cfg.init_en |-> cell_carry_out[CELLS-1] == slice_in[CELLS-1].second_lut_input_four)
    else $error("fourth input does not initialise carry");

  bypass_pass_a: assert property (
    cell_bypass[0] && !(HIGH_CAP && carry_cfg.init_en) |-> cell_carry_out[0] == cell_cin[0])
    else $error("bypassed cell altered carry");

  // the top cell bypass is checked too, though the bench only bypasses cells 0 and 1
  top_bypass_a: assert property (
    cell_bypass[CELLS-1] && !(HIGH_CAP && carry_cfg.init_en)
    |-> cell_carry_out[CELLS-1] == cell_cin[CELLS-1])
    else $error("bypassed top cell altered carry");

  // ram side: the glitch flag is a one-cycle echo of the address move
  glitch_pulse_a: assert property (
    1'b1 |=> ram_addr_glitch == $past(addr_move))
    else $error("address glitch flag does not follow the move");

  // a low strobe can never be blamed for a moved address
  glitch_quiet_a: assert property (
    !ram_req.we |=> !ram_addr_glitch)
    else $error("glitch flagged with enable low");

  // the move detector compares against last cycle's request
  addr_track_a: assert property (
    1'b1 |=> st_reg.addr_d == $past(ram_req.addr) && st_reg.we_d == $past(ram_req.we))
    else $error("previous request not kept for move detection");

  // a write touches only the addressed bit, even when it is a spurious one
  other_bits_a: assert property (
    ram_req.we |=> ((st_reg.mem ^ $past(st_reg.mem))
    & ~({{(LCR_DEPTH-1){1'b0}}, 1'b1} << $past(ram_req.addr))) == '0)
    else $error("write disturbed another ram bit");

  // the value present in the last high cycle is the one that stays
  falling_capture_a: assert property (
    ram_req.we && !addr_move ##1 !ram_req.we
    |-> st_reg.mem[$past(ram_req.addr)] == $past(ram_req.din))
    else $error("value at enable fall not kept");

  // column side: sums are registered straight from the slices
  sum_capture_a: assert property (
    1'b1 |=> sum_out == $past(cell_sum))
    else $error("sum output does not follow the slices");

  // the chain enters at the end that matches the direction
  up_entry_a: assert property (
    !eff_down |-> cell_cin[0] == carry_in_from_below)
    else $error("upward chain not fed from below");

  down_entry_a: assert property (
    eff_down |-> cell_cin[CELLS-1] == carry_in_from_above)
    else $error("downward chain not fed from above");

  // a downward column hands over the carry of its bottom cell
  down_turn_a: assert property (
    eff_down |=> carry_out == $past(cell_carry_out[0]))
    else $error("downward column end carry not passed right");

  // one slice is a full 2-bit adder on its own pins
  slice_add_a: assert property (
    !cell_bypass[0] && !(HIGH_CAP && carry_cfg.init_en)
    |-> {cell_carry_out[0], cell_sum[LCR_SLICE_W-1:0]} == cell0_total)
    else $error("bottom slice does not add its operands");

  // a bypassed slice still forms its sum from the passing carry
  bypass_sum_a: assert property (
    cell_bypass[0] |-> cell_sum[LCR_SLICE_W-1:0] == cell0_total[LCR_SLICE_W-1:0])
    else $error("bypassed slice sum ignores its carry");

  // reset must clear every output; checked with the default disable off
  reset_clear_a: assert property (
    @(posedge clk_sys) disable iff (1'b0)
    sys_rst |=> sum_out == '0 && !carry_out && !ram_rd_data && !ram_addr_glitch
    && st_reg.mem == LCR_MEM_RST)
    else $error("reset left state behind");

  // the top cell is joined to the cell below it when the chain runs up;
  // a single-cell column has no inner link to look at
  if (CELLS > 1) begin : g_link_chk
    chain_link_a: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      !eff_down |-> cell_cin[CELLS-1] == cell_carry_out[CELLS-2])
      else $error("inner carry link broken");
  end

endmodule : lcr_cell
`default_nettype wire

// file: sim/lcr_user_model.sv
// user logic model that drives the latch ram address, data and write strobe
// assumes the bench calls its tasks from one process, one at a time
`timescale 1ns/10ps
`default_nettype none
module lcr_user_model
  import lcr_pkg::*;
(
  input wire logic clk_sys,
  output var lcr_ram_req_type ram_req
);
  initial ram_req = '0;
  // one request per edge, changed only just after the edge
  task automatic put(input logic we, input logic [3:0] a, input logic d);
    @(posedge clk_sys);
    ram_req <= '{we: we, addr: a, din: d};
  endtask : put
  // strobe pulse framed by settled address and held data
  task automatic write(input logic [3:0] a, input logic d);
    put(1'b0, a, d);
    put(1'b1, a, d);
    put(1'b0, a, d);
  endtask : write
endmodule : lcr_user_model
`default_nettype wire

// file: sim/testbench.sv
// self-checking bench for the latch ram and carry column
// assumes the default of four standard cells on one system clock
`timescale 1ns/10ps
`default_nettype none
module testbench
  import lcr_pkg::*;
;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic cin_lo, cin_hi, sub, down;
    logic [3:0] byp;
    logic [8:0] exp;
  } lcr_row_type;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  lcr_ram_req_type ram_req;
  logic ram_rd_data, ram_addr_glitch, carry_out;
  logic carry_in_from_below = 1'b0;
  logic carry_in_from_above = 1'b0;
  lcr_slice_in_type [3:0] slice_in = '0;
  lcr_carry_cfg_type carry_cfg = '0;
  logic [3:0] cell_bypass = '0;
  logic [7:0] sum_out;
  int failures = 0;
  int n_compared = 0;
  // column word cases: add, overflow, subtract, both directions, bypass
  lcr_row_type rows [9] = '{
    '{8'h0F, 8'h01, 0, 0, 0, 0, 4'h0, 9'h010}, '{8'hFF, 8'h01, 0, 0, 0, 0, 4'h0, 9'h100},
    '{8'h80, 8'h80, 1, 0, 0, 0, 4'h0, 9'h101}, '{8'h05, 8'h03, 1, 0, 1, 0, 4'h0, 9'h102},
    '{8'h03, 8'h05, 1, 0, 1, 0, 4'h0, 9'h0FE}, '{8'hFF, 8'h00, 0, 1, 0, 1, 4'h0, 9'h100},
    '{8'hFF, 8'h00, 0, 1, 0, 0, 4'h0, 9'h0FF}, '{8'hC3, 8'h01, 0, 0, 0, 0, 4'h2, 9'h0D4},
    '{8'h01, 8'h01, 1, 0, 0, 0, 4'h1, 9'h007}};

  lcr_cell lcr_cell_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .ram_req(ram_req),
    .ram_rd_data(ram_rd_data), .ram_addr_glitch(ram_addr_glitch), .slice_in(slice_in),
    .carry_cfg(carry_cfg), .cell_bypass(cell_bypass), .carry_in_from_below(carry_in_from_below),
    .carry_in_from_above(carry_in_from_above), .sum_out(sum_out), .carry_out(carry_out));
  lcr_user_model lcr_user_model_inst (.clk_sys(clk_sys), .ram_req(ram_req));

  // 10 MHz system clock
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // read data lags the presented address by one edge
  task automatic read_bit(input logic [3:0] a, input logic exp);
    lcr_user_model_inst.put(1'b0, a, ~exp);
    @(posedge clk_sys);
    #1;
    check("ram_rd_data", {8'h00, exp}, {8'h00, ram_rd_data});
  endtask : read_bit

  // operands split two bits per cell, cell 0 lowest
  task automatic apply(input lcr_row_type r);
    @(posedge clk_sys);
    for (int i = 0; i < 4; i++) begin
      slice_in[i] <= '{op_a: r.a[2*i+:2], op_b: r.b[2*i+:2], second_lut_input_four: 1'b0};
    end
    carry_cfg <= '{subtract: r.sub, dir_down: r.down, init_en: 1'b0};
    cell_bypass <= r.byp;
    carry_in_from_below <= r.cin_lo;
    carry_in_from_above <= r.cin_hi;
    @(posedge clk_sys);
    #1;
  endtask : apply

  task automatic complete_run;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // main sequence: reset, table rows, then the awkward ram cases
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    check("reset column", 9'h000, {carry_out, sum_out});
    read_bit(4'h9, 1'b0);
    lcr_user_model_inst.put(1'b0, 4'h9, 1'b1);
    read_bit(4'h9, 1'b0);
    foreach (rows[k]) begin
      apply(rows[k]);
      check("column", rows[k].exp, {carry_out, sum_out});
    end
    lcr_user_model_inst.write(4'h3, 1'b1);
    read_bit(4'h3, 1'b1);
    // data moved under a held strobe lands in the same word
    lcr_user_model_inst.put(1'b1, 4'h6, 1'b0);
    lcr_user_model_inst.put(1'b1, 4'h6, 1'b1);
    lcr_user_model_inst.put(1'b0, 4'h6, 1'b1);
    read_bit(4'h6, 1'b1);
    // address moved under a held strobe, a deliberate driver fault
    lcr_user_model_inst.put(1'b1, 4'hA, 1'b1);
    lcr_user_model_inst.put(1'b1, 4'hB, 1'b1);
    lcr_user_model_inst.put(1'b0, 4'hB, 1'b1);
    #1;
    check("glitch high", 9'h001, {8'h00, ram_addr_glitch});
    @(posedge clk_sys);
    #1;
    check("glitch low", 9'h000, {8'h00, ram_addr_glitch});
    read_bit(4'hA, 1'b1);
    read_bit(4'hB, 1'b0);
    // reset in mid-run clears the store and the column
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    @(posedge clk_sys);
    #1;
    check("mid reset", 9'h000, {carry_out, sum_out});
    sys_rst <= 1'b0;
    read_bit(4'h3, 1'b0);
    complete_run();
  end

  // watchdog well past the fifty or so cycles the sequence needs
  initial begin
    repeat (3000) @(posedge clk_sys);
    failures++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
